// [hw/op_mode_map.vh]
// register offsets, field positions, reset values and codes for the mode controller
`ifndef OP_MODE_MAP_VH
`define OP_MODE_MAP_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define PMC_OFF          4'h0
`define OPT_OFF          4'h4
`define STAT_OFF         4'h8

// ****************************************************************
// field positions
// ****************************************************************
`define PMC_PPDS_BIT     0
`define PMC_ACK_BIT      1
`define PMC_WAKE_BIT     2
`define OPT_STOP_BIT     0
`define OPT_DBG_BIT      1
`define OPT_LVD_BIT      2

// ****************************************************************
// reset values
// ****************************************************************
`define PMC_RST          1'b0
`define OPT_RST          3'h0

// ****************************************************************
// modes
// ****************************************************************
`define MODE_INIT        3'h0
`define MODE_RUN         3'h1
`define MODE_BKG         3'h2
`define MODE_WAIT        3'h3
`define MODE_LSTOP       3'h4
`define MODE_DSTOP       3'h5

// ****************************************************************
// serial debug command classes
// ****************************************************************
`define CMD_MEM          3'h0
`define CMD_MEM_STAT     3'h1
`define CMD_DBG_REG      3'h2
`define CMD_HALT         3'h3
`define CMD_CPU_REG      3'h4
`define CMD_TRACE        3'h5
`define CMD_GO           3'h6

// ****************************************************************
// misc constants
// ****************************************************************
`define RESET_VECTOR     16'hFFFE
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

// [hw/pin_sync2.v]
// two flip-flop synchroniser for one asynchronous pin
`timescale 1ns/100ps
module pin_sync2
(
    // clock and reset
    input  wire mclk_i,
    input  wire sys_rst_i,
    // pin side
    input  wire async_i,
    // clock side
    output wire sync_o
);
    reg meta_q;
    reg sync_q;

    // no reset: the strap level must reach the far flop while reset is held
    always @(posedge mclk_i)
    begin
        meta_q <= async_i;
        sync_q <= meta_q;
    end

    assign sync_o = sync_q;
endmodule

// [hw/operating_mode_control.v]
// operating mode sequencer: run, background, wait and two stop modes
// Behaviour
// - pin high at reset release gives run
// - run start fetches reset vector 0xFFFE
// - four events enter background mode
// - background mode keeps cpu suspended
// - non-intrusive commands accepted in run, background
// - cpu, trace, go commands background only
// - wait stops cpu clock, system runs
// - wait entry clears interrupt mask
// - interrupt leaves wait, starts stacking
// - wait accepts only halt and status-access
// - status access in wait/stop returns error
// - halt command in wait enters background
// - stop with option set halts clocks
// - stop with option clear forces reset
// - select bit one gives deep stop
// - light stop keeps circuits powered
// - only deep and light stop exist
// - low-voltage detect in stop forces light
// - debug-in-stop forces light, debug clocked
// - deep wake sets flag, holds pins
`timescale 1ns/100ps
`include "op_mode_map.vh"
module operating_mode_control
(
    // clock and reset
    input  wire        mclk_i,
    input  wire        sys_rst_i,
    // debug pin (mode select while in reset)
    input  wire        debug_mode_select_pin_i,
    // cpu events
    input  wire        wait_exec_i,
    input  wire        stop_exec_i,
    input  wire        halt_to_debug_instruction_i,
    input  wire        dbg_breakpoint_i,
    input  wire        trace_breakpoint_i,
    input  wire        irq_req_i,
    input  wire        stop_wake_i,
    // serial debug command decode
    input  wire        cmd_valid_i,
    input  wire [2:0]  cmd_class_i,
    output reg         cmd_done_o,
    output reg         cmd_refused_o,
    output reg         cmd_stop_err_o,
    output reg         mem_access_o,
    // cpu and power controls
    output wire [2:0]  mode_o,
    output wire        cpu_clk_en_o,
    output wire        sys_clk_en_o,
    output wire        dbg_clk_en_o,
    output wire        reg_full_o,
    output wire        deep_off_o,
    output wire        pins_held_o,
    output reg         fetch_vector_o,
    output wire [15:0] vector_addr_o,
    output reg         clr_imask_o,
    output reg         irq_stack_o,
    output reg         illegal_rst_o,
    output reg         trace_step_o,
    // axi4-lite slave
    input  wire [3:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [3:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready
);
    // ****************************************************************
    // state
    // ****************************************************************
    reg  [2:0]  mode_q;
    reg         strap_q;
    reg         ppds_q;
    reg         wake_flag_q;
    reg         pin_hold_q;
    reg         stop_allow_q;
    reg         dbg_stop_q;
    reg         lvd_stop_q;
    reg         dbg_in_stop_q;
    reg  [3:0]  aw_addr_q;
    reg         aw_have_q;
    reg  [31:0] w_data_q;
    reg  [3:0]  w_strb_q;
    reg         w_have_q;
    wire        pin_sync;
    wire        wr_go;
    wire        ack_wr;
    wire        halt_cmd;
    wire        bkg_event;
    wire        in_stop;

    pin_sync2 u_pin_sync
    (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .async_i   (debug_mode_select_pin_i),
        .sync_o    (pin_sync)
    );

    function is_nonintrusive;
        input [2:0] c;
        begin
            is_nonintrusive = (c == `CMD_MEM) || (c == `CMD_MEM_STAT) ||
                              (c == `CMD_DBG_REG) || (c == `CMD_HALT);
        end
    endfunction

    function [31:0] zext3;
        input [2:0] v;
        begin
            zext3 = {29'h0000_0000, v};
        end
    endfunction

    // ****************************************************************
    // axi4-lite write path
    // ****************************************************************
    // address and data are caught independently, in either order
    assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
    assign wr_go         = aw_have_q && w_have_q && !s_axi_bvalid;
    assign ack_wr        = wr_go && (aw_addr_q == `PMC_OFF) && w_strb_q[0] &&
                           w_data_q[`PMC_ACK_BIT];

    always @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            aw_have_q    <= 1'b0;
            w_have_q     <= 1'b0;
            aw_addr_q    <= 4'h0;
            w_data_q     <= 32'h0000_0000;
            w_strb_q     <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RESP_OKAY;
            ppds_q       <= `PMC_RST;
            stop_allow_q <= 1'b0;
            dbg_stop_q   <= 1'b0;
            lvd_stop_q   <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_addr_q <= s_axi_awaddr;
                aw_have_q <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
                w_have_q <= 1'b1;
            end
            if (wr_go)
            begin
                aw_have_q    <= 1'b0;
                w_have_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `RESP_OKAY;
                case (aw_addr_q)
                    `PMC_OFF:
                    begin
                        if (w_strb_q[0])
                            ppds_q <= w_data_q[`PMC_PPDS_BIT];
                    end
                    `OPT_OFF:
                    begin
                        if (w_strb_q[0])
                        begin
                            stop_allow_q <= w_data_q[`OPT_STOP_BIT];
                            dbg_stop_q   <= w_data_q[`OPT_DBG_BIT];
                            lvd_stop_q   <= w_data_q[`OPT_LVD_BIT];
                        end
                    end
                    `STAT_OFF:
                    begin
                        s_axi_bresp <= `RESP_OKAY;
                    end
                    default:
                    begin
                        s_axi_bresp <= `RESP_SLVERR;
                    end
                endcase
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // axi4-lite read path
    // ****************************************************************
    assign s_axi_arready = !s_axi_rvalid;

    always @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `RESP_OKAY;
            case (s_axi_araddr)
                // acknowledge bit always reads back zero
                `PMC_OFF:
                    s_axi_rdata <= zext3({wake_flag_q, 1'b0, ppds_q});
                `OPT_OFF:
                    s_axi_rdata <= zext3({lvd_stop_q, dbg_stop_q, stop_allow_q});
                `STAT_OFF:
                    s_axi_rdata <= {24'h00_0000, 1'b0, pin_hold_q, strap_q, 2'b00,
                                    mode_q};
                default:
                begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ****************************************************************
    // mode sequencer
    // ****************************************************************
    assign halt_cmd  = cmd_valid_i && (cmd_class_i == `CMD_HALT);
    assign bkg_event = halt_cmd || halt_to_debug_instruction_i ||
                       dbg_breakpoint_i || trace_breakpoint_i;
    assign in_stop   = (mode_q == `MODE_LSTOP) || (mode_q == `MODE_DSTOP);

    always @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            mode_q         <= `MODE_INIT;
            strap_q        <= 1'b1;
            dbg_in_stop_q  <= 1'b0;
            wake_flag_q    <= 1'b0;
            pin_hold_q     <= 1'b0;
            fetch_vector_o <= 1'b0;
            clr_imask_o    <= 1'b0;
            irq_stack_o    <= 1'b0;
            illegal_rst_o  <= 1'b0;
        end
        else
        begin
            fetch_vector_o <= 1'b0;
            clr_imask_o    <= 1'b0;
            irq_stack_o    <= 1'b0;
            illegal_rst_o  <= 1'b0;
            // acknowledge releases the pins; a fresh deep wake wins over it
            if (ack_wr && (mode_q != `MODE_DSTOP))
            begin
                wake_flag_q <= 1'b0;
                pin_hold_q  <= 1'b0;
            end
            case (mode_q)
                `MODE_INIT:
                begin
                    // single decision on the first edge after release
                    strap_q <= pin_sync;
                    if (pin_sync)
                    begin
                        mode_q         <= `MODE_RUN;
                        fetch_vector_o <= 1'b1;
                    end
                    else
                    begin
                        mode_q <= `MODE_BKG;
                    end
                end
                `MODE_RUN:
                begin
                    if (bkg_event)
                    begin
                        mode_q <= `MODE_BKG;
                    end
                    else if (wait_exec_i)
                    begin
                        mode_q      <= `MODE_WAIT;
                        clr_imask_o <= 1'b1;
                    end
                    else if (stop_exec_i)
                    begin
                        if (!stop_allow_q)
                            illegal_rst_o <= 1'b1;
                        else if (lvd_stop_q || dbg_stop_q || !ppds_q)
                        begin
                            mode_q        <= `MODE_LSTOP;
                            dbg_in_stop_q <= dbg_stop_q;
                        end
                        else
                        begin
                            mode_q     <= `MODE_DSTOP;
                            pin_hold_q <= 1'b1;
                        end
                    end
                end
                `MODE_BKG:
                begin
                    // only the go command releases the suspended cpu
                    if (cmd_valid_i && (cmd_class_i == `CMD_GO))
                        mode_q <= `MODE_RUN;
                end
                `MODE_WAIT:
                begin
                    if (halt_cmd)
                    begin
                        mode_q <= `MODE_BKG;
                    end
                    else if (irq_req_i)
                    begin
                        mode_q      <= `MODE_RUN;
                        irq_stack_o <= 1'b1;
                    end
                end
                `MODE_LSTOP:
                begin
                    // halt wakes only when debug clocks were kept alive
                    if (halt_cmd && dbg_in_stop_q)
                    begin
                        mode_q        <= `MODE_BKG;
                        dbg_in_stop_q <= 1'b0;
                    end
                    else if (stop_wake_i)
                    begin
                        mode_q        <= `MODE_RUN;
                        irq_stack_o   <= 1'b1;
                        dbg_in_stop_q <= 1'b0;
                    end
                end
                `MODE_DSTOP:
                begin
                    // deep wake restarts as from power-on, pins stay latched
                    if (stop_wake_i)
                    begin
                        mode_q         <= `MODE_RUN;
                        fetch_vector_o <= 1'b1;
                        wake_flag_q    <= 1'b1;
                    end
                end
                default:
                begin
                    mode_q <= `MODE_INIT;
                end
            endcase
        end
    end

    // ****************************************************************
    // serial command gating
    // ****************************************************************
    always @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            cmd_done_o     <= 1'b0;
            cmd_refused_o  <= 1'b0;
            cmd_stop_err_o <= 1'b0;
            mem_access_o   <= 1'b0;
            trace_step_o   <= 1'b0;
        end
        else
        begin
            cmd_done_o     <= 1'b0;
            cmd_refused_o  <= 1'b0;
            cmd_stop_err_o <= 1'b0;
            mem_access_o   <= 1'b0;
            trace_step_o   <= 1'b0;
            if (cmd_valid_i)
            begin
                if ((mode_q == `MODE_WAIT) || in_stop)
                begin
                    if (cmd_class_i == `CMD_MEM_STAT)
                    begin
                        cmd_done_o     <= 1'b1;
                        cmd_stop_err_o <= 1'b1;
                    end
                    else if (halt_cmd && ((mode_q == `MODE_WAIT) || dbg_in_stop_q))
                        cmd_done_o <= 1'b1;
                    else
                        cmd_refused_o <= 1'b1;
                end
                else if ((mode_q == `MODE_RUN) && !is_nonintrusive(cmd_class_i))
                begin
                    cmd_refused_o <= 1'b1;
                end
                else if (mode_q == `MODE_INIT)
                begin
                    cmd_refused_o <= 1'b1;
                end
                else
                begin
                    cmd_done_o   <= 1'b1;
                    mem_access_o <= (cmd_class_i == `CMD_MEM) ||
                                    (cmd_class_i == `CMD_MEM_STAT);
                    trace_step_o <= (mode_q == `MODE_BKG) &&
                                    (cmd_class_i == `CMD_TRACE);
                end
            end
        end
    end

    // ****************************************************************
    // clock and power controls
    // ****************************************************************
    assign mode_o        = mode_q;
    assign vector_addr_o = `RESET_VECTOR;
    assign cpu_clk_en_o  = (mode_q == `MODE_RUN) || trace_step_o;
    assign sys_clk_en_o  = !in_stop;
    assign dbg_clk_en_o  = !in_stop || dbg_in_stop_q;
    // regulator stays full in light stop when debug or lvd needs it
    assign reg_full_o    = !in_stop || dbg_in_stop_q ||
                           ((mode_q == `MODE_LSTOP) && lvd_stop_q);
    assign deep_off_o    = (mode_q == `MODE_DSTOP);
    assign pins_held_o   = pin_hold_q;
endmodule

// [verif/mode_monitor.sv]
// concurrent checks on the operating mode sequencer ports
`timescale 1ns/100ps
`include "op_mode_map.vh"
module mode_monitor
(
    // clock and reset
    input wire        mclk_i,
    input wire        sys_rst_i,
    // watched ports
    input wire        cmd_valid_i,
    input wire [2:0]  cmd_class_i,
    input wire        cmd_done_o,
    input wire        cmd_refused_o,
    input wire        cmd_stop_err_o,
    input wire        mem_access_o,
    input wire [2:0]  mode_o,
    input wire        cpu_clk_en_o,
    input wire        sys_clk_en_o,
    input wire        clr_imask_o,
    input wire        illegal_rst_o,
    input wire        stop_exec_i,
    input wire        fetch_vector_o,
    input wire [15:0] vector_addr_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (sys_rst_i);
    sequence s_halt_wait;
        cmd_valid_i && cmd_class_i == `CMD_HALT && mode_o == `MODE_WAIT;
    endsequence
    sequence s_enter_wait;
        mode_o == `MODE_WAIT && $past(mode_o) != `MODE_WAIT;
    endsequence
    a_wait_clocks: assert property (mode_o == `MODE_WAIT |-> !cpu_clk_en_o && sys_clk_en_o)
        else $error("wrong clock enables in wait");
    a_wait_imask: assert property (s_enter_wait |-> clr_imask_o)
        else $error("mask not cleared on wait entry");
    a_active_refused: assert property (cmd_valid_i && cmd_class_i >= `CMD_CPU_REG
        && mode_o != `MODE_BKG |=> cmd_refused_o && !cmd_done_o)
        else $error("active command accepted outside background");
    a_nonintr_done: assert property (cmd_valid_i && cmd_class_i <= `CMD_HALT
        && (mode_o == `MODE_RUN || mode_o == `MODE_BKG) |=> cmd_done_o)
        else $error("non-intrusive command not accepted");
    a_status_err: assert property (cmd_valid_i && cmd_class_i == `CMD_MEM_STAT
        && mode_o >= `MODE_WAIT |=> cmd_stop_err_o && !mem_access_o)
        else $error("status access in low power without error");
    a_wait_filter: assert property (cmd_valid_i && mode_o == `MODE_WAIT && cmd_class_i != 1
        && cmd_class_i != 3 |=> cmd_refused_o)
        else $error("command accepted in wait");
    a_wait_halt: assert property (s_halt_wait |=> mode_o == `MODE_BKG)
        else $error("halt in wait did not enter background");
    a_stop_clocks: assert property (mode_o >= `MODE_LSTOP |-> !sys_clk_en_o && !cpu_clk_en_o)
        else $error("clocks running in stop");
    a_illegal_stop: assert property (illegal_rst_o |-> $past(stop_exec_i) && mode_o == `MODE_RUN)
        else $error("illegal reset request without stop");
    a_vector_fetch: assert property (fetch_vector_o |-> vector_addr_o == 16'hFFFE)
        else $error("wrong reset vector");
    a_two_stops: assert property (mode_o <= `MODE_DSTOP)
        else $error("undefined mode");
    a_bkg_hold: assert property (mode_o == `MODE_BKG && !cmd_valid_i |=> mode_o == `MODE_BKG)
        else $error("background left without command");
endmodule
bind operating_mode_control mode_monitor i_mon
(
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .cmd_valid_i(cmd_valid_i),
    .cmd_class_i(cmd_class_i), .cmd_done_o(cmd_done_o), .cmd_refused_o(cmd_refused_o),
    .cmd_stop_err_o(cmd_stop_err_o), .mem_access_o(mem_access_o), .mode_o(mode_o),
    .cpu_clk_en_o(cpu_clk_en_o), .sys_clk_en_o(sys_clk_en_o), .clr_imask_o(clr_imask_o),
    .illegal_rst_o(illegal_rst_o), .stop_exec_i(stop_exec_i),
    .fetch_vector_o(fetch_vector_o), .vector_addr_o(vector_addr_o)
);

// [verif/debug_host.sv]
// debug host model: mode strap and serial command requests
`timescale 1ns/100ps
module debug_host
(
    // clock
    input  wire        mclk_i,
    // pin and commands
    output wire        pin_o,
    output logic       cmd_valid_o,
    output logic [2:0] cmd_class_o
);
    logic strap_low = 1'b0;
    initial cmd_valid_o = 1'b0;
    initial cmd_class_o = 3'h0;
    // released pin rests high on its pull-up
    assign pin_o = strap_low ? 1'b0 : 1'b1;
    // idle class lines toggle so stale values never look valid
    task automatic send(input logic [2:0] c);
        @(posedge mclk_i);
        cmd_valid_o <= 1'b1;
        cmd_class_o <= c;
        @(posedge mclk_i);
        cmd_valid_o <= 1'b0;
        cmd_class_o <= ~c;
    endtask
endmodule

// [verif/testbench.sv]
// self-checking bench for the operating mode sequencer
`timescale 1ns/100ps
module testbench;
    logic        mclk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic [6:0]  evt = 7'h00;
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h1;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0;
    wire         debug_mode_select_pin_i, cmd_valid_i, wait_exec_i, stop_exec_i, irq_req_i;
    wire         halt_to_debug_instruction_i, dbg_breakpoint_i, trace_breakpoint_i, stop_wake_i;
    wire [2:0]   cmd_class_i, mode_o;
    wire         cmd_done_o, cmd_refused_o, cmd_stop_err_o, mem_access_o, cpu_clk_en_o;
    wire         sys_clk_en_o, dbg_clk_en_o, reg_full_o, deep_off_o, pins_held_o;
    wire         fetch_vector_o, clr_imask_o, irq_stack_o, illegal_rst_o, trace_step_o;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0]   s_axi_bresp, s_axi_rresp;
    wire [15:0]  vector_addr_o;
    wire [31:0]  s_axi_rdata;
    int          fail_count = 0;
    int          check_count = 0;
    assign {stop_wake_i, irq_req_i, trace_breakpoint_i, dbg_breakpoint_i,
            halt_to_debug_instruction_i, stop_exec_i, wait_exec_i} = evt;
    always #5 mclk_i = ~mclk_i;
    operating_mode_control i_dut (.*);
    debug_host i_host (.mclk_i(mclk_i), .pin_o(debug_mode_select_pin_i),
                       .cmd_valid_o(cmd_valid_i), .cmd_class_o(cmd_class_i));
    task automatic final_report;
        if (fail_count == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // a bounded wait that ran out ends the run
    task automatic tmo(input int n);
        if (n >= 64)
        begin
            chk("timeout", 0, 1);
            final_report;
        end
    endtask
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge mclk_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge mclk_i);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 64);
        s_axi_bready <= 1'b0;
        tmo(n);
        chk("bresp", er, s_axi_bresp);
    endtask
    task automatic axi_rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge mclk_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge mclk_i);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 64);
        s_axi_rready <= 1'b0;
        tmo(n);
        chk("rdata", ed, s_axi_rdata);
        chk("rresp", er, s_axi_rresp);
    endtask
    task automatic ev(input int i, input logic [2:0] em);
        @(posedge mclk_i);
        evt[i] <= 1'b1;
        @(posedge mclk_i);
        evt[i] <= 1'b0;
        #1;
        chk("mode", em, mode_o);
    endtask
    task automatic cmd(input logic [2:0] c, input logic ok, input logic [2:0] em);
        i_host.send(c);
        #1;
        chk("done", ok, cmd_done_o);
        chk("refused", !ok, cmd_refused_o);
        chk("mode", em, mode_o);
        chk("mem", ok && c < 2 && em < 3, mem_access_o);
        chk("trace", ok && c == 5, trace_step_o);
    endtask
    task automatic boot(input logic pin, input logic [2:0] em);
        @(posedge mclk_i);
        i_host.strap_low <= !pin;
        sys_rst_i <= 1'b1;
        repeat (4) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        @(posedge mclk_i);
        #1;
        chk("mode", em, mode_o);
        chk("fetch", pin, fetch_vector_o);
    endtask
    initial
    begin
        boot(1'b0, 2);
        i_host.strap_low = 1'b0;
        repeat (4) @(posedge mclk_i);
        chk("mode", 2, mode_o);
        cmd(6, 1'b1, 1);
        boot(1'b1, 1);
        chk("vector", 16'hFFFE, vector_addr_o);
        axi_wr(4'hC, 32'h0000_0001, 2'h2);
        axi_rd(4'hC, 32'h0000_0000, 2'h2);
        for (int c = 0; c < 7; c++)
            if (c != 3) cmd(c[2:0], c < 3, 1);
        cmd(3, 1'b1, 2);
        for (int c = 4; c < 7; c++)
            cmd(c[2:0], 1'b1, (c == 6) ? 3'h1 : 3'h2);
        for (int i = 2; i < 5; i++)
        begin
            ev(i, 2);
            cmd(6, 1'b1, 1);
        end
        ev(0, 3);
        chk("cpu_clk", 0, cpu_clk_en_o);
        cmd(0, 1'b0, 3);
        cmd(1, 1'b1, 3);
        chk("stop_err", 1, cmd_stop_err_o);
        cmd(3, 1'b1, 2);
        cmd(6, 1'b1, 1);
        ev(0, 3);
        ev(5, 1);
        chk("stack", 1, irq_stack_o);
        ev(1, 1);
        chk("illegal_rst", 1, illegal_rst_o);
        axi_wr(4'h4, 32'h0000_0001, 2'h0);
        axi_wr(4'h0, 32'h0000_0001, 2'h0);
        ev(1, 5);
        chk("deep_off", 1, deep_off_o);
        chk("reg_full", 0, reg_full_o);
        cmd(1, 1'b1, 5);
        cmd(3, 1'b0, 5);
        ev(6, 1);
        axi_rd(4'h0, 32'h0000_0005, 2'h0);
        chk("pins_held", 1, pins_held_o);
        axi_wr(4'h0, 32'h0000_0003, 2'h0);
        axi_rd(4'h0, 32'h0000_0001, 2'h0);
        axi_wr(4'h4, 32'h0000_0005, 2'h0);
        ev(1, 4);
        chk("reg_full", 1, reg_full_o);
        ev(6, 1);
        axi_wr(4'h4, 32'h0000_0003, 2'h0);
        ev(1, 4);
        chk("dbg_clk", 1, dbg_clk_en_o);
        cmd(3, 1'b1, 2);
        final_report;
    end
endmodule
